// *** design/flash_cmd_regs.svh ***
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// ************************************************
// register map (byte addresses)
// ************************************************
`define FL_STATUS_OFS 12'h000
`define FL_COMMAND_OFS 12'h004
`define FL_ADDR_OFS 12'h008
`define FL_DIV_OFS 12'h00C
`define FL_ENGINE_OFS 12'h010

// ************************************************
// field positions and codes
// ************************************************
`define FL_BIT_CBEF 7
`define FL_BIT_CCF 6
`define FL_BIT_PVIOL 5
`define FL_BIT_ACCERR 4
`define FL_BIT_BLANK 2
`define FL_CMD_VERIFY 7'h05
`define FL_CMD_PROG 7'h20
`define FL_CMD_BURST 7'h25
`define FL_CMD_SECTOR 7'h40
`define FL_CMD_MASS 7'h41
`define FL_STATUS_RST 8'hC0
`define FL_DIV_RST 8'h00
`define FL_BUSY_CYCLES 16'h0010

`endif

// *** design/flash_cmd_pkg.sv ***
package flash_cmd_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ADDR = 2'b01,
    SEQ_CMD = 2'b10
  } seq_state_t;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_RUN = 2'b01
  } eng_state_t;
endpackage

// *** design/flash_cmd_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"
module flash_cmd_engine
  import flash_cmd_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [CNT_W-1:0] cycles_i,
  output logic busy_o,
  output logic done_o
);
  typedef struct packed {
    eng_state_t st;
    logic [CNT_W-1:0] cnt;
    logic done;
  } eng_t;
  eng_t q_r, q_nxt;

  // stand-in timer for the program/erase algorithm
  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    unique case (q_r.st)
      ENG_IDLE: begin
        if (start_i) begin
          q_nxt.st = ENG_RUN;
          q_nxt.cnt = cycles_i;
        end
      end
      ENG_RUN: begin
        if (q_r.cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          q_nxt.st = ENG_IDLE;
          q_nxt.done = 1'b1;
        end else begin
          q_nxt.cnt = q_r.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      // spare state code: fall back to idle
      default: begin
        q_nxt.st = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '{st: ENG_IDLE, cnt: '0, done: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign busy_o = (q_r.st == ENG_RUN);
  assign done_o = q_r.done;
endmodule
`default_nettype wire

// *** design/flash_cmd_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"
module flash_cmd_status_regs
  import flash_cmd_pkg::*;
#(
  parameter logic [15:0] BUSY_CYCLES = `FL_BUSY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // side signals to and from the rest of the flash module
  input wire logic protect_hit_i,
  input wire logic verify_blank_i,
  input wire logic cpu_stop_i,
  output logic busy_o
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cbef;
    logic ccf;
    logic pviol;
    logic accerr;
    logic blank;
    logic [6:0] cmd;
    seq_state_t seq;
    logic div_loaded;
    logic [7:0] div;
    logic pend;
    logic [6:0] pend_cmd;
    logic [6:0] act_cmd;
    logic eng_start;
    logic busy;
    logic stop_s1;
    logic stop_s2;
    logic stop_s3;
  } regs_t;
  regs_t q_r, q_nxt;

  logic eng_busy;
  logic eng_done;

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic cmd_valid(input logic [6:0] c);
    return (c == `FL_CMD_VERIFY) || (c == `FL_CMD_PROG) || (c == `FL_CMD_BURST) ||
           (c == `FL_CMD_SECTOR) || (c == `FL_CMD_MASS);
  endfunction

  function automatic logic is_alter(input logic [6:0] c);
    return c != `FL_CMD_VERIFY;
  endfunction

  function automatic logic [7:0] status_byte(input regs_t s);
    logic [7:0] b;
    b = 8'h00;
    b[`FL_BIT_CBEF] = s.cbef;
    b[`FL_BIT_CCF] = s.ccf;
    b[`FL_BIT_PVIOL] = s.pviol;
    b[`FL_BIT_ACCERR] = s.accerr;
    b[`FL_BIT_BLANK] = s.blank;
    return b;
  endfunction

  flash_cmd_engine #(
    .CNT_W(16)
  ) u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(q_r.eng_start),
    .cycles_i(BUSY_CYCLES),
    .busy_o(eng_busy),
    .done_o(eng_done)
  );

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    logic wr_go;
    logic [7:0] wb;
    logic blocked;
    logic launch;
    wr_go = 1'b0;
    wb = 8'h00;
    blocked = 1'b0;
    launch = 1'b0;
    q_nxt = q_r;
    q_nxt.eng_start = 1'b0;
    // stop pin crosses from cpu core domain
    q_nxt.stop_s1 = cpu_stop_i;
    q_nxt.stop_s2 = q_r.stop_s1;
    q_nxt.stop_s3 = q_r.stop_s2;

    // write channel capture, either order
    if (s_axi_awvalid && !q_r.aw_got) begin
      q_nxt.aw_got = 1'b1;
      q_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q_r.w_got) begin
      q_nxt.w_got = 1'b1;
      q_nxt.wdata = s_axi_wdata;
      q_nxt.wstrb = s_axi_wstrb;
    end
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
    end
    wr_go = q_r.aw_got && q_r.w_got && !q_r.bvalid;
    wb = q_r.wstrb[0] ? q_r.wdata[7:0] : 8'h00;
    blocked = q_r.pviol || q_r.accerr;

    // engine finished: fetch pending command or report completion
    if (eng_done) begin
      if (q_r.pend) begin
        q_nxt.pend = 1'b0;
        q_nxt.act_cmd = q_r.pend_cmd;
        q_nxt.eng_start = 1'b1;
        q_nxt.cbef = 1'b1;
      end else begin
        q_nxt.busy = 1'b0;
        q_nxt.cbef = 1'b1;
        q_nxt.ccf = 1'b1;
        if (q_r.act_cmd == `FL_CMD_VERIFY) begin
          q_nxt.blank = verify_blank_i;
        end
      end
    end

    // stop executed while a command runs
    if (q_r.stop_s2 && !q_r.stop_s3 && !q_r.ccf) begin
      q_nxt.accerr = 1'b1;
    end

    if (wr_go) begin
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = 2'b00;
      unique case (q_r.awaddr[11:2])
        `FL_ADDR_OFS >> 2: begin
          // array address write opens the sequence
          if (q_r.seq == SEQ_IDLE && q_r.cbef && !blocked) begin
            q_nxt.seq = SEQ_ADDR;
            if (protect_hit_i) begin
              q_nxt.pviol = 1'b1;
              q_nxt.seq = SEQ_IDLE;
            end
          end else if (q_r.seq != SEQ_IDLE) begin
            q_nxt.accerr = 1'b1;
            q_nxt.seq = SEQ_IDLE;
          end
        end
        `FL_COMMAND_OFS >> 2: begin
          if (q_r.seq == SEQ_ADDR && q_r.wstrb[0]) begin
            q_nxt.cmd = wb[6:0];
            if (!cmd_valid(wb[6:0])) begin
              q_nxt.accerr = 1'b1;
              q_nxt.seq = SEQ_IDLE;
            end else begin
              q_nxt.seq = SEQ_CMD;
            end
          end else if (q_r.seq != SEQ_IDLE) begin
            q_nxt.accerr = 1'b1;
            q_nxt.seq = SEQ_IDLE;
          end
        end
        `FL_DIV_OFS >> 2: begin
          // writable once and only with no access error
          if (!q_r.div_loaded && !q_r.accerr && q_r.wstrb[0]) begin
            q_nxt.div = wb;
            q_nxt.div_loaded = 1'b1;
          end
        end
        `FL_STATUS_OFS >> 2: begin
          if (q_r.wstrb[0]) begin
            if (wb[`FL_BIT_CBEF]) begin
              launch = (q_r.seq == SEQ_CMD) && !blocked;
              if (q_r.seq != SEQ_IDLE && !launch) begin
                q_nxt.accerr = 1'b1;
                q_nxt.seq = SEQ_IDLE;
              end
            end else if (q_r.seq != SEQ_IDLE) begin
              q_nxt.accerr = 1'b1;
              q_nxt.seq = SEQ_IDLE;
            end
            // zero written while idle: no effect at all
            // violation only sets on an array write, never here
            if (wb[`FL_BIT_PVIOL]) begin
              q_nxt.pviol = 1'b0;
            end
            // set wins: a stop edge in the same cycle keeps the error
            if (wb[`FL_BIT_ACCERR] && q_r.accerr && !(q_r.stop_s2 && !q_r.stop_s3 && !q_r.ccf)) begin
              q_nxt.accerr = 1'b0;
            end
          end
        end
        default: begin
          q_nxt.bresp = 2'b10;
        end
      endcase
    end

    if (launch) begin
      q_nxt.seq = SEQ_IDLE;
      q_nxt.cbef = 1'b0;
      q_nxt.ccf = 1'b0;
      q_nxt.blank = 1'b0;
      if (!q_r.div_loaded) begin
        q_nxt.accerr = 1'b1;
        q_nxt.cbef = 1'b1;
        q_nxt.ccf = 1'b1;
      end else if (q_r.busy) begin
        // any command may queue behind a running burst
        q_nxt.pend = 1'b1;
        q_nxt.pend_cmd = q_r.cmd;
      end else begin
        q_nxt.busy = 1'b1;
        q_nxt.act_cmd = q_r.cmd;
        q_nxt.eng_start = 1'b1;
        q_nxt.cbef = is_alter(q_r.cmd) && (q_r.cmd == `FL_CMD_BURST);
      end
    end

    // read channel
    if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q_r.rvalid) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = 2'b00;
      unique case (s_axi_araddr[11:2])
        `FL_STATUS_OFS >> 2: q_nxt.rdata = {24'h000000, status_byte(q_r)};
        `FL_COMMAND_OFS >> 2: q_nxt.rdata = {25'h0000000, q_r.cmd};
        `FL_ADDR_OFS >> 2: q_nxt.rdata = 32'h00000000;
        `FL_DIV_OFS >> 2: q_nxt.rdata = {23'h000000, q_r.div_loaded, q_r.div};
        `FL_ENGINE_OFS >> 2: q_nxt.rdata = {30'h00000000, q_r.pend, eng_busy};
        default: begin
          q_nxt.rdata = 32'h00000000;
          q_nxt.rresp = 2'b10;
        end
      endcase
    end
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
      q_r.cbef <= 1'b1;
      q_r.ccf <= 1'b1;
      q_r.seq <= SEQ_IDLE;
      q_r.div <= `FL_DIV_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign s_axi_awready = !q_r.aw_got;
  assign s_axi_wready = !q_r.w_got;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_arready = !q_r.rvalid;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rdata = q_r.rdata;
  assign s_axi_rresp = q_r.rresp;
  assign busy_o = q_r.busy;
endmodule
`default_nettype wire

// *** tb/flash_cmd_status_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_status_regs_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic busy_o
);
  // ****
  // bus answers and status outputs
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_b_clear;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_clear: assert property (p_b_clear) else $error("bvalid stuck");
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("no write answer");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("no read answer");
  property p_hi_zero;
    s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
  property p_reset;
    $fell(rst_i) |-> !s_axi_bvalid && !s_axi_rvalid && !busy_o;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
  property p_busy_end;
    $rose(busy_o) |-> ##[1:300] !busy_o;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("command never ends");
endmodule
`default_nettype wire

// *** tb/cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"
module cpu_model (
  input wire logic clk_i,
  output logic [11:0] awaddr_o = 12'h000,
  output logic awvalid_o = 1'b0,
  input wire logic awready_i,
  output logic [31:0] wdata_o = 32'h0,
  output logic wvalid_o = 1'b0,
  input wire logic wready_i,
  input wire logic bvalid_i,
  output logic bready_o = 1'b0,
  output logic [11:0] araddr_o = 12'h000,
  output logic arvalid_o = 1'b0,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o = 1'b0
);
  // ****
  // bus cycles
  // ****
  // address and data offered together, each dropped once taken
  // handshakes judged mid-cycle, so the edge that takes them is known
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= {24'h0, d};
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge clk_i);
      aw_hs = awvalid_o && (awready_i === 1'b1);
      w_hs = wvalid_o && (wready_i === 1'b1);
      b_hs = (bvalid_i === 1'b1);
      @(posedge clk_i);
      if (aw_hs) awvalid_o <= 1'b0;
      if (w_hs) wvalid_o <= 1'b0;
    end
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge clk_i);
      ar_hs = arvalid_o && (arready_i === 1'b1);
      r_hs = (rvalid_i === 1'b1);
      d = rdata_i;
      r = rresp_i;
      @(posedge clk_i);
      if (ar_hs) arvalid_o <= 1'b0;
    end
    rready_o <= 1'b0;
  endtask
  // no other flash write may slip between the three steps
  task automatic seq(input logic [7:0] c);
    wr(`FL_ADDR_OFS, 8'h00);
    wr(`FL_COMMAND_OFS, c);
    wr(`FL_STATUS_OFS, 8'h80);
  endtask
endmodule
`default_nettype wire

// *** tb/flash_cmd_status_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"
module flash_cmd_status_regs_tb_top;
  // ****
  // bench
  // ****
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, busy_o;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic protect_hit_i = 1'b0, verify_blank_i = 1'b0, cpu_stop_i = 1'b0;
  int errors = 0, total_checks = 0, cyc = 0;
  // longer engine run so a burst can be queued behind a running one
  flash_cmd_status_regs #(.BUSY_CYCLES(16'h0040)) flash_cmd_status_regs_i (.*);
  cpu_model cpu_model_i (.clk_i(clk_i), .awaddr_o(s_axi_awaddr), .awvalid_o(s_axi_awvalid),
    .awready_i(s_axi_awready), .wdata_o(s_axi_wdata), .wvalid_o(s_axi_wvalid),
    .wready_i(s_axi_wready), .bvalid_i(s_axi_bvalid), .bready_o(s_axi_bready),
    .araddr_o(s_axi_araddr), .arvalid_o(s_axi_arvalid), .arready_i(s_axi_arready),
    .rdata_i(s_axi_rdata), .rresp_i(s_axi_rresp), .rvalid_i(s_axi_rvalid),
    .rready_o(s_axi_rready));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // hang guard, far above the whole run
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // upper bits always compared, low byte under mask
  task automatic chk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    cpu_model_i.rd(a, d, r);
    cmp({24'h0, e}, d & {24'hFFFFFF, m});
  endtask
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    cpu_model_i.wr(a, d);
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    cmp(32'h0, {31'h0, busy_o});
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk(`FL_STATUS_OFS, 8'hFF, `FL_STATUS_RST);
    chk(`FL_COMMAND_OFS, 8'hFF, 8'h00);
    cpu_model_i.rd(12'h040, d, r);
    cmp(32'h2, {30'h0, r});
    w(12'h040, 8'h00);
    cmp(32'h2, {30'h0, s_axi_bresp});
    cpu_model_i.seq({1'b0, `FL_CMD_PROG});
    chk(`FL_STATUS_OFS, 8'h10, 8'h10);
    w(`FL_STATUS_OFS, 8'h10);
    chk(`FL_STATUS_OFS, 8'hFF, 8'hC0);
    w(`FL_DIV_OFS, 8'h13);
    $display("t_reset done");
  endtask
  task automatic t_codes();
    logic [6:0] c [5];
    c = '{`FL_CMD_VERIFY, `FL_CMD_PROG, `FL_CMD_BURST, `FL_CMD_SECTOR, `FL_CMD_MASS};
    verify_blank_i <= 1'b1;
    foreach (c[i]) begin
      w(`FL_ADDR_OFS, 8'h00);
      w(`FL_COMMAND_OFS, {1'b0, c[i]});
      chk(`FL_COMMAND_OFS, 8'hFF, {1'b0, c[i]});
      w(`FL_STATUS_OFS, 8'h80);
      chk(`FL_STATUS_OFS, 8'hC0, (c[i] == `FL_CMD_BURST) ? 8'h80 : 8'h00);
      idle();
      chk(`FL_STATUS_OFS, 8'hFF, (i == 0) ? 8'hC4 : 8'hC0);
    end
    // second burst queued while the first runs
    cpu_model_i.seq({1'b0, `FL_CMD_BURST});
    cpu_model_i.seq({1'b0, `FL_CMD_BURST});
    chk(`FL_ENGINE_OFS, 8'h03, 8'h03);
    repeat (70) @(posedge clk_i);
    chk(`FL_STATUS_OFS, 8'h40, 8'h00);
    cmp(32'h1, {31'h0, busy_o});
    idle();
    chk(`FL_STATUS_OFS, 8'hFF, 8'hC0);
    verify_blank_i <= 1'b0;
    cpu_model_i.seq({1'b0, `FL_CMD_VERIFY});
    idle();
    chk(`FL_STATUS_OFS, 8'hFF, 8'hC0);
    $display("t_codes done");
  endtask
  task automatic t_errs();
    w(`FL_STATUS_OFS, 8'h0F);
    chk(`FL_STATUS_OFS, 8'hFF, 8'hC0);
    w(`FL_ADDR_OFS, 8'h00);
    w(`FL_STATUS_OFS, 8'h00);
    chk(`FL_STATUS_OFS, 8'hFF, 8'hD0);
    w(`FL_STATUS_OFS, 8'h10);
    w(`FL_ADDR_OFS, 8'h00);
    w(`FL_COMMAND_OFS, 8'hFF);
    chk(`FL_COMMAND_OFS, 8'hFF, 8'h7F);
    w(`FL_STATUS_OFS, 8'h00);
    chk(`FL_STATUS_OFS, 8'h10, 8'h10);
    w(`FL_STATUS_OFS, 8'h10);
    chk(`FL_STATUS_OFS, 8'hFF, 8'hC0);
    $display("t_errs done");
  endtask
  task automatic t_protect();
    protect_hit_i <= 1'b1;
    cpu_model_i.seq({1'b0, `FL_CMD_SECTOR});
    chk(`FL_STATUS_OFS, 8'h20, 8'h20);
    protect_hit_i <= 1'b0;
    cpu_model_i.seq({1'b0, `FL_CMD_PROG});
    cmp(32'h0, {31'h0, busy_o});
    chk(`FL_STATUS_OFS, 8'hE0, 8'hE0);
    w(`FL_STATUS_OFS, 8'h30);
    chk(`FL_STATUS_OFS, 8'hFF, 8'hC0);
    $display("t_protect done");
  endtask
  // a stop only counts while a command runs
  task automatic t_stop();
    for (int k = 0; k < 2; k++) begin
      if (k == 1) cpu_model_i.seq({1'b0, `FL_CMD_PROG});
      cpu_stop_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      cpu_stop_i <= 1'b0;
      idle();
      chk(`FL_STATUS_OFS, 8'hFF, (k == 1) ? 8'hD0 : 8'hC0);
    end
    w(`FL_STATUS_OFS, 8'h10);
    $display("t_stop done");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_codes();
    t_errs();
    t_protect();
    t_stop();
    test_done();
  end
endmodule
bind flash_cmd_status_regs flash_cmd_status_regs_asserts flash_cmd_status_regs_asserts_i (.*);
`default_nettype wire
